// File: rtl/hcc_decoder.sv
// Host command decoder of the keypad and port companion chip.
// Assumes a serial slave framer in front that hands over whole bytes: a
// frame start pulse, write bytes with a valid pulse and read requests.
`timescale 1ns/100ps

`include "hcc_regs.svh"

// Overview of operation
// - Identify returns maker byte then revision byte.
// - Configuration command stores one data byte.
// - Configuration holds 0x80 after any reset.
// - Bit 7 picks open-drain or push-pull interrupt.
// - Bit 6 enables the rotary encoder inputs.
// - Bit 3 enables second selector output, overriding.
// - Bit 2 picks second selector source.
// - Bit 1 enables first selector; bit 0 source.
// - Interrupt read returns code, acknowledges, clears.
// - Awaiting setup blocks the clear until configuration.
// - Bits 7..5 flag channel script ends.
// - Bit 4 shows awaiting host setup.
// - Bit 3 flags an error condition.
// - Bit 1 rotation, bit 0 key, bit 2 zero.
// - Reset command with key 0xAA resets device.
// - Wrong reset key: no reset, raise error.
// - After command reset hold interrupt high 60 ms.
// - Pull command sets pull up or down.
// - First byte pins 15..8, second 7..0.
// - Direction command sets input or output.
// - Pin 9 never drives, only pulled input.
// - State command sets pull enable or level.
// - Configuration read returns the register.
// - Direction read returns both direction bytes.
module hcc_decoder #(
  parameter logic [7:0]  MAKER_CODE        = 8'h5A,  // Arbitrary value.
  parameter logic [7:0]  REVISION_CODE     = 8'h01,  // Arbitrary value.
  parameter bit          READY_PULSE_EN    = 1'b1,
  parameter int unsigned READY_HOLD_CYCLES = `HCC_READY_HOLD_MS * `HCC_CLK_KHZ,
  parameter int unsigned PORT_WIDTH        = 16
) (
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Byte port from the serial framer.
  input  wire logic                  i_frame_start,
  input  wire logic                  i_wr_valid,
  input  wire logic [7:0]            i_wr_data,
  input  wire logic                  i_rd_req,
  output logic                       o_rd_valid,
  output logic [7:0]                 o_rd_data,
  // Events from the rest of the chip.
  input  wire logic [2:0]            i_chan_done,
  input  wire logic                  i_error_event,
  input  wire logic                  i_rotation_event,
  input  wire logic                  i_key_event,
  // Interrupt pin, active low.
  output logic                       o_irq_n_out,
  output logic                       o_irq_n_oe,
  // Rotary encoder enable for the keypad column pins.
  output logic                       o_rotary_enable,
  // First selector.
  input  wire logic                  i_first_selector_in_a,
  input  wire logic                  i_first_selector_in_b,
  output logic                       o_first_selector_output,
  output logic                       o_first_selector_oe,
  // Second selector.
  input  wire logic                  i_second_selector_in_a,
  input  wire logic                  i_second_selector_in_b,
  output logic                       o_second_selector_output,
  output logic                       o_second_selector_oe,
  // Port pins.
  output logic [PORT_WIDTH-1:0]      o_port_pin_out,
  output logic [PORT_WIDTH-1:0]      o_port_pin_oe,
  output logic [PORT_WIDTH-1:0]      o_port_pull_en,
  output logic [PORT_WIDTH-1:0]      o_port_pull_down
);

  // ***************************************************************
  // Checks and declarations
  // ***************************************************************

  // The byte layout of the port commands fixes the port at two bytes.
  initial begin
    if (PORT_WIDTH != 16) begin
      $error("PORT_WIDTH must be 16.");
    end
    if (READY_HOLD_CYCLES < 1 || READY_HOLD_CYCLES > 32'h00FFFFFF) begin
      $error("READY_HOLD_CYCLES must lie between 1 and 2**24-1.");
    end
  end

  hcc_pkg::hcc_phase_t phase_reg;
  logic [7:0]          cmd_reg;
  logic [1:0]          wr_idx_reg;
  logic [1:0]          rd_idx_reg;
  logic [7:0]          stage_reg;
  logic                soft_rst_reg;
  logic [7:0]          cfg_reg;
  logic [15:0]         pull_reg;
  logic [15:0]         dir_reg;
  logic [15:0]         level_reg;
  logic                await_reg;
  logic [2:0]          chan_reg;
  logic                err_reg;
  logic                rot_reg;
  logic                key_reg;
  logic [23:0]         hold_reg;
  logic [7:0]          int_code;
  logic                cmd_byte;
  logic                data_byte;
  logic                known_cmd;
  logic                bad_key;
  logic                int_ack;
  logic                irq_active;
  logic [7:0]          rd_next;

  // ***************************************************************
  // Byte framing
  // ***************************************************************

  // The first written byte of a frame is the command; the rest are data.
  assign cmd_byte  = i_wr_valid && phase_reg == hcc_pkg::HCC_WAIT_CMD;
  assign data_byte = i_wr_valid && phase_reg == hcc_pkg::HCC_HAVE_CMD;

  // A command byte outside the full command set of the chip is unknown.
  // Commands served by other blocks are let through without complaint.
  assign known_cmd = (i_wr_data >= `HCC_CMD_IDENTIFY && i_wr_data <= `HCC_CMD_DIR_RD) ||
                     (i_wr_data >= `HCC_CMD_OTHER_LO && i_wr_data <= `HCC_CMD_OTHER_HI &&
                      i_wr_data != `HCC_CMD_HOLE);

  // A repeated start keeps the command so that a read can follow its write.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_reg  <= hcc_pkg::HCC_WAIT_CMD;
      cmd_reg    <= `HCC_BYTE_ZERO;
      wr_idx_reg <= 2'h0;
    end else if (soft_rst_reg || i_frame_start) begin
      phase_reg  <= hcc_pkg::HCC_WAIT_CMD;
      wr_idx_reg <= 2'h0;
      if (soft_rst_reg) begin
        cmd_reg <= `HCC_BYTE_ZERO;
      end
    end else begin
      unique case (phase_reg)
        hcc_pkg::HCC_WAIT_CMD: begin
          if (i_wr_valid) begin
            cmd_reg   <= i_wr_data;
            phase_reg <= hcc_pkg::HCC_HAVE_CMD;
          end
        end
        hcc_pkg::HCC_HAVE_CMD: begin
          if (i_wr_valid && wr_idx_reg != 2'h3) begin
            wr_idx_reg <= wr_idx_reg + 2'h1;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // Configuration and reset commands
  // ***************************************************************

  // Every reset, including the command reset, restores the default.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= `HCC_CFG_RESET;
    end else if (soft_rst_reg) begin
      cfg_reg <= `HCC_CFG_RESET;
    end else if (data_byte && cmd_reg == `HCC_CMD_CFG_WR && wr_idx_reg == 2'h0) begin
      cfg_reg <= i_wr_data;
    end
  end

  assign bad_key = data_byte && cmd_reg == `HCC_CMD_RESET && wr_idx_reg == 2'h0 &&
                   i_wr_data != `HCC_RESET_KEY;

  // The reset is taken one cycle after the key; it clears the registers other than stage_reg, o_rd_data, hold_reg, o_rotary_enable and the interrupt pin ones.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= data_byte && cmd_reg == `HCC_CMD_RESET && wr_idx_reg == 2'h0 &&
                      i_wr_data == `HCC_RESET_KEY;
    end
  end

  // ***************************************************************
  // Port pin commands
  // ***************************************************************

  // The high byte waits in a stage so that all sixteen pins change at once.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_reg <= `HCC_BYTE_ZERO;
    end else if (data_byte && wr_idx_reg == 2'h0) begin
      stage_reg <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pull_reg  <= `HCC_WORD_ZERO;
      dir_reg   <= `HCC_WORD_ZERO;
      level_reg <= `HCC_WORD_ZERO;
    end else if (soft_rst_reg) begin
      pull_reg  <= `HCC_WORD_ZERO;
      dir_reg   <= `HCC_WORD_ZERO;
      level_reg <= `HCC_WORD_ZERO;
    end else if (data_byte && wr_idx_reg == 2'h1) begin
      if (cmd_reg == `HCC_CMD_PULL_WR) begin
        pull_reg <= {stage_reg, i_wr_data};
      end
      if (cmd_reg == `HCC_CMD_DIR_WR) begin
        dir_reg <= {stage_reg, i_wr_data};
      end
      if (cmd_reg == `HCC_CMD_STATE_WR) begin
        level_reg <= {stage_reg, i_wr_data};
      end
    end
  end

  // One pad controller per pin; the input-only pin is built without a driver.
  for (genvar g = 0; g < PORT_WIDTH; g++) begin : g_port
    hcc_port_bit #(
      .INPUT_ONLY (g == `HCC_INPUT_ONLY_PIN)
    ) u_port_bit (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_dir       (dir_reg[g]),
      .i_level     (level_reg[g]),
      .i_pull_down (pull_reg[g]),
      .o_out       (o_port_pin_out[g]),
      .o_oe        (o_port_pin_oe[g]),
      .o_pull_en   (o_port_pull_en[g]),
      .o_pull_down (o_port_pull_down[g])
    );
  end

  // ***************************************************************
  // Selectors and rotary enable
  // ***************************************************************

  hcc_selector u_first_selector (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_enable (cfg_reg[`HCC_CFG_SEL1_EN]),
    .i_source (cfg_reg[`HCC_CFG_SEL1_SRC]),
    .i_in_a   (i_first_selector_in_a),
    .i_in_b   (i_first_selector_in_b),
    .o_out    (o_first_selector_output),
    .o_oe     (o_first_selector_oe)
  );

  hcc_selector u_second_selector (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_enable (cfg_reg[`HCC_CFG_SEL2_EN]),
    .i_source (cfg_reg[`HCC_CFG_SEL2_SRC]),
    .i_in_a   (i_second_selector_in_a),
    .i_in_b   (i_second_selector_in_b),
    .o_out    (o_second_selector_output),
    .o_oe     (o_second_selector_oe)
  );

  // The column pins switch to rotation inputs while this is high.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rotary_enable <= 1'b0;
    end else begin
      o_rotary_enable <= cfg_reg[`HCC_CFG_ROT_EN];
    end
  end

  // ***************************************************************
  // Interrupt code
  // ***************************************************************

  assign int_code = {chan_reg, await_reg, err_reg, 1'b0, rot_reg, key_reg};

  // Acknowledge on the first byte read; blocked while setup is awaited.
  assign int_ack = i_rd_req && cmd_reg == `HCC_CMD_INT_RD && rd_idx_reg == 2'h0 &&
                   !await_reg;

  // Setup is awaited from every reset until the configuration command.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      await_reg <= 1'b1;
    end else if (soft_rst_reg) begin
      await_reg <= 1'b1;
    end else if (data_byte && cmd_reg == `HCC_CMD_CFG_WR && wr_idx_reg == 2'h0) begin
      await_reg <= 1'b0;
    end
  end

  // Sticky event bits: an event in the clearing cycle survives the clear.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_reg <= 3'h0;
      err_reg  <= 1'b0;
      rot_reg  <= 1'b0;
      key_reg  <= 1'b0;
    end else if (soft_rst_reg) begin
      chan_reg <= 3'h0;
      err_reg  <= 1'b0;
      rot_reg  <= 1'b0;
      key_reg  <= 1'b0;
    end else begin
      chan_reg <= (chan_reg & {3{~int_ack}}) | i_chan_done;
      err_reg  <= (err_reg & ~int_ack) | i_error_event | bad_key |
                  (cmd_byte & ~known_cmd);
      rot_reg  <= (rot_reg & ~int_ack) |
                  (i_rotation_event & cfg_reg[`HCC_CFG_ROT_EN]);
      key_reg  <= (key_reg & ~int_ack) | i_key_event;
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************

  // Bytes past the defined ones, and reads of write commands, return zero.
  always_comb begin
    rd_next = `HCC_BYTE_ZERO;
    unique case (cmd_reg)
      `HCC_CMD_IDENTIFY: begin
        if (rd_idx_reg == 2'h0) begin
          rd_next = MAKER_CODE;
        end else if (rd_idx_reg == 2'h1) begin
          rd_next = REVISION_CODE;
        end
      end
      `HCC_CMD_INT_RD: begin
        if (rd_idx_reg == 2'h0) begin
          rd_next = int_code;
        end
      end
      `HCC_CMD_DIR_RD: begin
        if (rd_idx_reg == 2'h0) begin
          rd_next = dir_reg[15:8];
        end else if (rd_idx_reg == 2'h1) begin
          rd_next = dir_reg[7:0];
        end
      end
      `HCC_CMD_CFG_RD: begin
        if (rd_idx_reg == 2'h0) begin
          rd_next = cfg_reg;
        end
      end
      default: begin
        rd_next = `HCC_BYTE_ZERO;
      end
    endcase
  end

  // Each request outside a frame start or command reset cycle is answered one cycle later with a one-cycle valid pulse.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= `HCC_BYTE_ZERO;
      rd_idx_reg <= 2'h0;
    end else if (soft_rst_reg || i_frame_start) begin
      o_rd_valid <= 1'b0;
      rd_idx_reg <= 2'h0;
    end else begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req) begin
        o_rd_data <= rd_next;
        if (rd_idx_reg != 2'h3) begin
          rd_idx_reg <= rd_idx_reg + 2'h1;
        end
      end
    end
  end

  // ***************************************************************
  // Interrupt pin
  // ***************************************************************

  // A command reset loads the hold; the line is held high until it ends.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_reg <= 24'h000000;
    end else if (soft_rst_reg && READY_PULSE_EN) begin
      hold_reg <= READY_HOLD_CYCLES[23:0];
    end else if (hold_reg != 24'h000000) begin
      hold_reg <= hold_reg - 24'h000001;
    end
  end

  // Awaited setup asserts the line once no hold is running, which signals readiness.
  assign irq_active = (|int_code) && hold_reg == 24'h000000 && !soft_rst_reg;

  // Push-pull drives both levels; open-drain drives only the low level.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_n_out <= 1'b1;
      o_irq_n_oe  <= 1'b0;
    end else if (cfg_reg[`HCC_CFG_IRQ_PP]) begin
      o_irq_n_out <= ~irq_active;
      o_irq_n_oe  <= 1'b1;
    end else begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe  <= irq_active;
    end
  end

endmodule // hcc_decoder

// File: rtl/hcc_pkg.sv
// Types shared by the host command decoder files.
// Assumes nothing of its surroundings.
package hcc_pkg;

  // Progress of a write frame: waiting for the command byte or past it.
  typedef enum logic {
    HCC_WAIT_CMD,
    HCC_HAVE_CMD
  } hcc_phase_t;

endpackage

// File: rtl/hcc_port_bit.sv
// Pad control of one general purpose port pin.
// Assumes the pad has a weak pull device of selectable polarity.
`timescale 1ns/100ps

module hcc_port_bit #(
  parameter bit INPUT_ONLY = 1'b0
) (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Settings.
  input  wire logic i_dir,
  input  wire logic i_level,
  input  wire logic i_pull_down,
  // Pad.
  output logic      o_out,
  output logic      o_oe,
  output logic      o_pull_en,
  output logic      o_pull_down
);

  logic drive;

  // An input-only pin ignores the direction and keeps its pull on.
  assign drive = i_dir & ~INPUT_ONLY;

  // Outputs drive the level; inputs float or take the weak pull.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_out       <= 1'b0;
      o_oe        <= 1'b0;
      o_pull_en   <= 1'b0;
      o_pull_down <= 1'b0;
    end else begin
      o_oe        <= drive;
      o_out       <= drive & i_level;
      o_pull_en   <= ~drive & (i_level | INPUT_ONLY);
      o_pull_down <= i_pull_down;
    end
  end

endmodule // hcc_port_bit

// File: rtl/hcc_regs.svh
// Command codes, field positions, reset values and timing figures of the
// host command decoder. Included by the decoder design file and by the bench.
`ifndef HCC_REGS_SVH
`define HCC_REGS_SVH

// Command bytes.
`define HCC_CMD_IDENTIFY   8'h80
`define HCC_CMD_CFG_WR     8'h81
`define HCC_CMD_INT_RD     8'h82
`define HCC_CMD_RESET      8'h83
`define HCC_CMD_PULL_WR    8'h84
`define HCC_CMD_DIR_WR     8'h85
`define HCC_CMD_STATE_WR   8'h86
`define HCC_CMD_DIR_RD     8'h87
`define HCC_CMD_CFG_RD     8'h92
`define HCC_CMD_OTHER_LO   8'h88
`define HCC_CMD_OTHER_HI   8'h97
`define HCC_CMD_HOLE       8'h8D

// Reset key and reset values.
`define HCC_RESET_KEY      8'hAA
`define HCC_CFG_RESET      8'h80
`define HCC_BYTE_ZERO      8'h00
`define HCC_WORD_ZERO      16'h0000

// Hardware configuration fields.
`define HCC_CFG_IRQ_PP     7
`define HCC_CFG_ROT_EN     6
`define HCC_CFG_SEL2_EN    3
`define HCC_CFG_SEL2_SRC   2
`define HCC_CFG_SEL1_EN    1
`define HCC_CFG_SEL1_SRC   0

// Interrupt code fields.
`define HCC_INT_CHAN_LSB   5
`define HCC_INT_AWAIT      4
`define HCC_INT_ERR        3
`define HCC_INT_ZERO       2
`define HCC_INT_ROT        1
`define HCC_INT_KEY        0

// Port pin that can never drive.
`define HCC_INPUT_ONLY_PIN 9

// Ready indication after a command reset.
`define HCC_READY_HOLD_MS  60
`define HCC_CLK_KHZ        250000

`endif

// File: rtl/hcc_selector.sv
// One signal selector output of the companion chip.
// Assumes both sources are synchronous to i_clk.
`timescale 1ns/100ps

module hcc_selector (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Configuration.
  input  wire logic i_enable,
  input  wire logic i_source,
  // Sources.
  input  wire logic i_in_a,
  input  wire logic i_in_b,
  // Pin.
  output logic      o_out,
  output logic      o_oe
);

  // The enabled selector owns the pin outright; disabled, it lets go.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_out <= 1'b0;
      o_oe  <= 1'b0;
    end else begin
      o_oe  <= i_enable;
      o_out <= i_enable & (i_source ? i_in_b : i_in_a);
    end
  end

endmodule // hcc_selector

// File: test/hcc_dec_asserts.sv
// Port checker for the host command decoder.
// Assumes it is bound onto hcc_decoder and sees only its ports.
`timescale 1ns/100ps

module hcc_dec_asserts #(
  parameter int unsigned PORT_WIDTH = 16
) (
  // Clock, reset and requests.
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  input wire logic                  i_wr_valid,
  input wire logic                  i_rd_req,
  input wire logic                  i_key_event,
  // Answers and pins.
  input wire logic                  o_rd_valid,
  input wire logic                  o_irq_n_out,
  input wire logic                  o_irq_n_oe,
  input wire logic                  o_rotary_enable,
  input wire logic                  o_first_selector_output,
  input wire logic                  o_first_selector_oe,
  input wire logic                  o_second_selector_output,
  input wire logic                  o_second_selector_oe,
  input wire logic [PORT_WIDTH-1:0] o_port_pin_out,
  input wire logic [PORT_WIDTH-1:0] o_port_pin_oe,
  input wire logic [PORT_WIDTH-1:0] o_port_pull_en
);
  // All checks share the one clock domain and its reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // The interrupt pin shows a request: driven and low.
  sequence s_irq_on;
    o_irq_n_oe && !o_irq_n_out;
  endsequence

  property p_rd_answer;  i_rd_req |=> o_rd_valid;  endproperty
  property p_rd_spur;  o_rd_valid |-> $past(i_rd_req);  endproperty
  property p_boot_irq;  $rose(i_resetn) |-> ##[1:3] s_irq_on;  endproperty
  property p_key_irq;  i_key_event |-> ##[1:4] s_irq_on;  endproperty
  // A high level is only ever driven, never left floating.
  property p_irq_high;  o_irq_n_out && $past(i_resetn) |-> o_irq_n_oe;  endproperty
  property p_sel1_off;  !o_first_selector_oe |-> !o_first_selector_output;  endproperty
  property p_sel2_off;  !o_second_selector_oe |-> !o_second_selector_output;  endproperty
  property p_pin9;  !o_port_pin_oe[9];  endproperty
  property p_out_dir;  (o_port_pin_out & ~o_port_pin_oe) == '0;  endproperty
  property p_pull_dir;  (o_port_pull_en & o_port_pin_oe) == '0;  endproperty
  // The rotary enable only moves two or three cycles after a written byte.
  property p_rot_cause;
    !$stable(o_rotary_enable) |-> $past(i_wr_valid, 2) || $past(i_wr_valid, 3);
  endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  a_rd_spur: assert property (p_rd_spur) else $error("read answer without request");
  a_boot_irq: assert property (p_boot_irq) else $error("no request after reset");
  a_key_irq: assert property (p_key_irq) else $error("key event left pin idle");
  a_irq_high: assert property (p_irq_high) else $error("interrupt high undriven");
  a_sel1_off: assert property (p_sel1_off) else $error("first selector leaks");
  a_sel2_off: assert property (p_sel2_off) else $error("second selector leaks");
  a_pin9: assert property (p_pin9) else $error("pin nine drives");
  a_out_dir: assert property (p_out_dir) else $error("level on input pin");
  a_pull_dir: assert property (p_pull_dir) else $error("pull on output pin");
  a_rot_cause: assert property (p_rot_cause) else $error("rotary enable moved");
endmodule // hcc_dec_asserts

bind hcc_decoder hcc_dec_asserts #(.PORT_WIDTH(PORT_WIDTH)) i_chk (
  .i_clk, .i_resetn, .i_wr_valid, .i_rd_req, .i_key_event, .o_rd_valid,
  .o_irq_n_out, .o_irq_n_oe, .o_rotary_enable, .o_first_selector_output,
  .o_first_selector_oe, .o_second_selector_output, .o_second_selector_oe,
  .o_port_pin_out, .o_port_pin_oe, .o_port_pull_en
);

// File: test/hcc_host.sv
// Host model: frames command and data bytes onto the decoder byte port.
// Assumes the decoder answers a read request exactly one cycle later.
`timescale 1ns/100ps

module hcc_host (
  // Clock and answers.
  input  wire logic       i_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  // Requests.
  output logic            o_frame_start = 1'b0,
  output logic            o_wr_valid    = 1'b0,
  output logic [7:0]      o_wr_data     = 8'h00,
  output logic            o_rd_req      = 1'b0
);
  // One bus cycle; an idle data bus shows the inverse so stale bytes never match.
  task automatic step(input logic fs, input logic wv, input logic [7:0] d, input logic rr);
    @(posedge i_clk);
    o_frame_start <= fs;
    o_wr_valid    <= wv;
    o_wr_data     <= wv ? d : ~o_wr_data;
    o_rd_req      <= rr;
  endtask

  // Write frame: start, command, then n data bytes with the high byte first.
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    step(1'b1, 1'b0, 8'h00, 1'b0);
    step(1'b0, 1'b1, c, 1'b0);
    if (n == 2) step(1'b0, 1'b1, d[15:8], 1'b0);
    if (n > 0) step(1'b0, 1'b1, d[7:0], 1'b0);
    step(1'b0, 1'b0, 8'h00, 1'b0);
  endtask

  // Read frame: command, repeated start, n read bytes taken as they answer.
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] q);
    wr(c, 16'h0000, 0);
    step(1'b1, 1'b0, 8'h00, 1'b0);
    q = 16'h0000;
    for (int k = 0; k < n; k++) begin
      step(1'b0, 1'b0, 8'h00, 1'b1);
      step(1'b0, 1'b0, 8'h00, 1'b0);
      #1;
      q = {q[7:0], (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX};
    end
  endtask
endmodule // hcc_host

// File: test/tb_top.sv
// Self-checking bench of the host command decoder.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
`include "hcc_regs.svh"

module tb_top;
  localparam logic [7:0]  MAKER = 8'h3C;  // Arbitrary value.
  localparam logic [7:0]  REV   = 8'h07;  // Arbitrary value.
  localparam int unsigned HOLD  = 20;
  localparam logic [15:0] DIR   = 16'hF2F3;
  localparam logic [15:0] LVL   = 16'h3C6A;
  localparam logic [7:0]  CFGS [4] = '{8'hCD, 8'h4A, 8'h07, 8'hC0};
  logic        clk = 1'b0, resetn = 1'b0, fs, wv, rr, rv, kev = 1'b0, eev = 1'b0, rev = 1'b0;
  logic        s1a = 1'b0, s1b = 1'b1, s2a = 1'b0, s2b = 1'b1;
  logic        iro, ire, rot, s1o, s1e, s2o, s2e;
  logic [2:0]  chd = 3'b000;
  logic [7:0]  wd, rdd, c;
  logic [15:0] q, pout, poe, pen, pdn;
  int          bad_count = 0, cmp_count = 0;

  // Free-running clock.
  initial begin
    forever #2 clk = ~clk;
  end

  hcc_decoder #(.MAKER_CODE(MAKER), .REVISION_CODE(REV), .READY_HOLD_CYCLES(HOLD)) i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_frame_start(fs), .i_wr_valid(wv), .i_wr_data(wd),
    .i_rd_req(rr), .o_rd_valid(rv), .o_rd_data(rdd), .i_chan_done(chd),
    .i_error_event(eev), .i_rotation_event(rev), .i_key_event(kev), .o_irq_n_out(iro),
    .o_irq_n_oe(ire), .o_rotary_enable(rot), .i_first_selector_in_a(s1a),
    .i_first_selector_in_b(s1b), .o_first_selector_output(s1o), .o_first_selector_oe(s1e),
    .i_second_selector_in_a(s2a), .i_second_selector_in_b(s2b),
    .o_second_selector_output(s2o), .o_second_selector_oe(s2e), .o_port_pin_out(pout),
    .o_port_pin_oe(poe), .o_port_pull_en(pen), .o_port_pull_down(pdn));

  hcc_host i_host (.i_clk(clk), .i_rd_valid(rv), .i_rd_data(rdd), .o_frame_start(fs),
    .o_wr_valid(wv), .o_wr_data(wd), .o_rd_req(rr));

  // Comparison with a count of every check made.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let n edges pass, then look once their updates have landed.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    kev <= 1'b1;
    @(posedge clk);
    kev <= 1'b0;
    wt(2);
    chk(16'({ire, iro}), 16'h0002);
    i_host.rd(`HCC_CMD_CFG_RD, 1, q);
    chk(q, 16'h0080);
    i_host.rd(`HCC_CMD_INT_RD, 1, q);
    chk(q, 16'h0011);
    i_host.rd(`HCC_CMD_INT_RD, 1, q);
    chk(q, 16'h0011);
    wt(2);
    chk(16'({ire, iro}), 16'h0002);
    i_host.rd(`HCC_CMD_IDENTIFY, 2, q);
    chk(q, {MAKER, REV});
    $display("test reset_identify done");
    // Each setting swaps the selector sources so a wrong pick shows.
    foreach (CFGS[i]) begin
      c = CFGS[i];
      @(posedge clk);
      {s1a, s1b, s2a, s2b} <= i[0] ? 4'b1001 : 4'b0110;
      i_host.wr(`HCC_CMD_CFG_WR, {8'h00, c}, 1);
      i_host.rd(`HCC_CMD_INT_RD, 1, q);
      wt(3);
      chk(16'(rot), 16'(c[6]));
      chk(16'({s1e, s1o}), 16'({c[1], c[1] & (c[0] ? s1b : s1a)}));
      chk(16'({s2e, s2o}), 16'({c[3], c[3] & (c[2] ? s2b : s2a)}));
      chk(16'({ire, iro}), c[7] ? 16'h0003 : 16'h0000);
      i_host.rd(`HCC_CMD_CFG_RD, 1, q);
      chk(q, {8'h00, c});
    end
    $display("test configuration done");
    @(posedge clk);
    {kev, rev, eev, chd} <= 6'b111101;
    @(posedge clk);
    {kev, rev, eev, chd} <= 6'b000000;
    wt(3);
    chk(16'({ire, iro}), 16'h0002);
    i_host.rd(`HCC_CMD_INT_RD, 1, q);
    chk(q, 16'h00AB);
    wt(2);
    chk(16'({ire, iro}), 16'h0003);
    i_host.rd(`HCC_CMD_INT_RD, 1, q);
    chk(q, 16'h0000);
    i_host.wr(`HCC_CMD_HOLE, 16'h0055, 1);
    i_host.rd(`HCC_CMD_INT_RD, 1, q);
    chk(q, 16'h0008);
    i_host.wr(`HCC_CMD_RESET, 16'h0055, 1);
    i_host.rd(`HCC_CMD_INT_RD, 1, q);
    chk(q, 16'h0008);
    i_host.rd(`HCC_CMD_CFG_RD, 1, q);
    chk(q, 16'h00C0);
    $display("test interrupts done");
    i_host.wr(`HCC_CMD_DIR_WR, DIR, 2);
    i_host.wr(`HCC_CMD_PULL_WR, 16'hA5C3, 2);
    i_host.wr(`HCC_CMD_STATE_WR, LVL, 2);
    wt(3);
    chk(poe, DIR & 16'hFDFF);
    chk(pout, DIR & LVL & 16'hFDFF);
    chk(pen, (~DIR & LVL) | 16'h0200);
    chk(pdn, 16'hA5C3);
    i_host.rd(`HCC_CMD_DIR_RD, 2, q);
    chk(q, DIR);
    $display("test ports done");
    i_host.wr(`HCC_CMD_RESET, 16'h00AA, 1);
    wt(2);
    chk(16'({ire, iro}), 16'h0003);
    wt(HOLD - 3);
    chk(16'({ire, iro}), 16'h0003);
    wt(5);
    chk(16'({ire, iro}), 16'h0002);
    chk(poe, 16'h0000);
    i_host.rd(`HCC_CMD_CFG_RD, 1, q);
    chk(q, 16'h0080);
    $display("test command reset done");
    finish_test();
  end
endmodule // tb_top
